// File: temp_fmt_consts.vh
// Purpose: Shared constants of the temperature result formatter.
// Assumes: Results are handled internally in quarter degrees.
// Notes: Signed limits are 14-bit two's complement patterns.
`ifndef TEMP_FMT_CONSTS_VH
`define TEMP_FMT_CONSTS_VH

// Register addresses.
`define ADDR_REMOTE_ONE_VALUE 8'h25
`define ADDR_LOCAL_TEMPERATURE_VALUE 8'h26
`define ADDR_REMOTE_TWO_VALUE 8'h27
`define ADDR_REMOTE_ONE_OFFSET 8'h70
`define ADDR_LOCAL_OFFSET 8'h71
`define ADDR_REMOTE_TWO_OFFSET 8'h72
`define ADDR_TEMPERATURE_FRACTION_BITS 8'h77
`define ADDR_RANGE_CONFIG 8'h7c

// Reset values.
`define OFFSET_RESET 8'h00
`define RANGE_CONFIG_RESET 2'h0
`define RESULT_RESET 8'h00
`define FRACTION_RESET 2'h0

// Field positions in the range configuration register.
`define CFG_TWOS_BIT 1
`define CFG_WIDE_TWOS_BIT 0

// Field positions in the fraction register.
`define FRAC_REMOTE_TWO_HI 7
`define FRAC_LOCAL_HI 5
`define FRAC_REMOTE_ONE_HI 3

// Averaging count and its counter width.
`define AVG_SAMPLES 16
`define AVG_SHIFT 4

// Channel codes on the sensor select lines.
`define CHAN_LOCAL 2'h0
`define CHAN_REMOTE_ONE 2'h1
`define CHAN_REMOTE_TWO 2'h2

// Excitation current codes: base only, first and second multiple.
`define CUR_BASE 2'h0
`define CUR_FIRST_MULT 2'h1
`define CUR_SECOND_MULT 2'h2

// Range limits in quarter degrees, 14-bit two's complement.
`define TWOS_MIN_FULL 14'h3e00
`define TWOS_MIN_CLAMP 14'h3f00
`define TWOS_MAX 14'h01ff
`define EXT_BIAS 14'h0100
`define EXT_MIN 14'h0000
`define EXT_MAX 14'h03ff

`endif

// File: sample_averager.v
// Purpose: Averages a fixed number of signed conversion samples.
// Assumes: Sample count is a power of two given by its shift.
// Notes: Emits one averaged value and a one-cycle valid pulse.
`timescale 1ns/10ps
`include "temp_fmt_consts.vh"

module sample_averager #(
	parameter WIDTH = 12,
	parameter SHIFT = `AVG_SHIFT
) (
	// Clock and reset.
	input wire mclk,
	input wire sys_rst,
	// Sample stream.
	input wire samp_vld,
	input wire signed [WIDTH-1:0] samp,
	// Averaged result.
	output reg signed [WIDTH-1:0] avg_ff,
	output reg avg_vld_ff
);

	reg signed [WIDTH+SHIFT-1:0] sum_ff;
	reg [SHIFT-1:0] cnt_ff;
	wire signed [WIDTH+SHIFT-1:0] nxt_sum;

	// Sign-extend the sample to the accumulator width.
	assign nxt_sum = sum_ff + {{SHIFT{samp[WIDTH-1]}}, samp};

	// The sum is cleared explicitly after each full set; the counter wraps on its own.
	always @(posedge mclk) begin
		if (sys_rst) begin
			sum_ff <= {(WIDTH+SHIFT){1'b0}};
			cnt_ff <= {SHIFT{1'b0}};
			avg_ff <= {WIDTH{1'b0}};
			avg_vld_ff <= 1'b0;
		end else begin
			avg_vld_ff <= 1'b0;
			if (samp_vld) begin
				cnt_ff <= cnt_ff + 1'b1;
				if (&cnt_ff) begin
					avg_ff <= nxt_sum[WIDTH+SHIFT-1:SHIFT];
					avg_vld_ff <= 1'b1;
					sum_ff <= {(WIDTH+SHIFT){1'b0}};
				end else begin
					sum_ff <= nxt_sum;
				end
			end
		end
	end

endmodule // sample_averager

// File: temp_result_formatter.v
// Purpose: Sequences conversions and formats averaged temperatures.
// Assumes: The analog front end runs on mclk and returns signed
//   quarter-degree codes with a one-cycle done pulse.
// Notes: Results can be frozen for a consistent two-register read.
`timescale 1ns/10ps
`include "temp_fmt_consts.vh"

// What this block does
// - Local integer byte goes to 0x26.
// - Store as twos complement or offset-64.
// - Ranges -128..127 or -64..191, quarter degree.
// - Local sensor plus two remote diode channels.
// - Remote: base/first, then base/second multiple.
// - Average sixteen samples per result; a remote sample is two conversions.
// - Remote result is ten-bit twos complement.
// - Two low bits go to fraction register.
// - Twos codes: -128, zero, +127 as shown.
// - Offset-64 codes: -64, zero, +191 as shown.
// - Add channel offset before storing result.
// - Offset is signed, half-degree LSB.
// - Fraction fields at 7:6, 5:4, 3:2.
// - Fraction read freezes results until all read.
// - Range bit 1 selects twos complement; bit 0 lifts the -64 floor.
module temp_result_formatter #(
	parameter CONV_WIDTH = 12
) (
	// Clock and reset.
	input wire mclk,
	input wire sys_rst,
	// Register port.
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata_ff,
	// Analog front end control.
	output reg conv_start_ff,
	output reg [1:0] chan_sel_ff,
	output reg [1:0] cur_mult_ff,
	// Analog front end result.
	input wire conv_done,
	input wire signed [CONV_WIDTH-1:0] conv_data
);

	// One-hot sequencer states.
	localparam ST_START = 3'b001;
	localparam ST_WAIT = 3'b010;
	localparam ST_STORE = 3'b100;

	reg [2:0] state_ff;
	reg [1:0] chan_ff;
	reg phase_ff;
	reg [`AVG_SHIFT-1:0] samp_cnt_ff;
	reg signed [CONV_WIDTH-1:0] delta_one_ff;

	// Software registers.
	reg [7:0] off_loc_ff;
	reg [7:0] off_r1_ff;
	reg [7:0] off_r2_ff;
	reg [1:0] range_cfg_ff;

	// Latest results, written once per averaged channel result.
	reg [7:0] live_loc_ff;
	reg [7:0] live_r1_ff;
	reg [7:0] live_r2_ff;
	reg [1:0] live_loc_frac_ff;
	reg [1:0] live_r1_frac_ff;
	reg [1:0] live_r2_frac_ff;

	// Visible results, held while frozen.
	reg [7:0] vis_loc_ff;
	reg [7:0] vis_r1_ff;
	reg [7:0] vis_r2_ff;
	reg [7:0] vis_frac_ff;

	// Freeze tracking.
	reg freeze_ff;
	reg [2:0] seen_ff;

	wire is_remote;
	wire samp_vld;
	wire [CONV_WIDTH:0] pair_sum;
	wire signed [CONV_WIDTH-1:0] samp;
	wire signed [CONV_WIDTH-1:0] avg;
	wire avg_vld;
	reg [7:0] sel_off;
	wire signed [13:0] corr;
	wire signed [13:0] ext_val;
	reg [9:0] code;
	wire [9:0] ext_code;
	wire [9:0] twos_code;
	wire signed [13:0] twos_lo;
	wire rd_frac;
	wire [2:0] nxt_seen;
	wire [2:0] rd_hit;

	assign is_remote = (chan_ff != `CHAN_LOCAL);

	// A sample is complete after one local or two remote conversions.
	assign samp_vld = state_ff[1] & conv_done & ~(is_remote & ~phase_ff);

	// The two difference readings are combined by their mean.
	assign pair_sum = {delta_one_ff[CONV_WIDTH-1], delta_one_ff}
		+ {conv_data[CONV_WIDTH-1], conv_data};
	assign samp = is_remote ? pair_sum[CONV_WIDTH:1] : conv_data;

	sample_averager #(
		.WIDTH(CONV_WIDTH),
		.SHIFT(`AVG_SHIFT)
	) u_avg (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.samp_vld(samp_vld),
		.samp(samp),
		.avg_ff(avg),
		.avg_vld_ff(avg_vld)
	);

	// Pick the offset that belongs to the channel being finished.
	always @* begin
		case (chan_ff)
			`CHAN_REMOTE_ONE: sel_off = off_r1_ff;
			`CHAN_REMOTE_TWO: sel_off = off_r2_ff;
			default: sel_off = off_loc_ff;
		endcase
	end

	// Offset LSB is half a degree, so it counts two quarters.
	assign corr = {{(14-CONV_WIDTH){avg[CONV_WIDTH-1]}}, avg}
		+ {{5{sel_off[7]}}, sel_off, 1'b0};

	// Extended range adds a 64-degree bias before clamping.
	assign ext_val = corr + `EXT_BIAS;
	assign ext_code = (ext_val < $signed(`EXT_MIN)) ? 10'h000 :
		(ext_val > $signed(`EXT_MAX)) ? 10'h3ff : ext_val[9:0];

	// The -64 floor applies unless the wide twos option is set.
	assign twos_lo = range_cfg_ff[`CFG_WIDE_TWOS_BIT] ?
		`TWOS_MIN_FULL : `TWOS_MIN_CLAMP;
	assign twos_code = (corr < twos_lo) ? twos_lo[9:0] :
		(corr > $signed(`TWOS_MAX)) ? 10'h1ff : corr[9:0];

	// Range bit selects twos complement over offset-64.
	always @* begin
		if (range_cfg_ff[`CFG_TWOS_BIT])
			code = twos_code;
		else
			code = ext_code;
	end

	// Conversion sequencer: local, remote one, remote two, repeat.
	always @(posedge mclk) begin
		if (sys_rst) begin
			state_ff <= ST_START;
			chan_ff <= `CHAN_LOCAL;
			phase_ff <= 1'b0;
			samp_cnt_ff <= {`AVG_SHIFT{1'b0}};
			delta_one_ff <= {CONV_WIDTH{1'b0}};
			conv_start_ff <= 1'b0;
			chan_sel_ff <= `CHAN_LOCAL;
			cur_mult_ff <= `CUR_BASE;
		end else begin
			case (state_ff)
				ST_START: begin
					conv_start_ff <= 1'b1;
					chan_sel_ff <= chan_ff;
					if (!is_remote)
						cur_mult_ff <= `CUR_BASE;
					else if (!phase_ff)
						cur_mult_ff <= `CUR_FIRST_MULT;
					else
						cur_mult_ff <= `CUR_SECOND_MULT;
					state_ff <= ST_WAIT;
				end
				ST_WAIT: begin
					conv_start_ff <= 1'b0;
					if (conv_done) begin
						if (is_remote && !phase_ff) begin
							delta_one_ff <= conv_data;
							phase_ff <= 1'b1;
							state_ff <= ST_START;
						end else begin
							phase_ff <= 1'b0;
							samp_cnt_ff <= samp_cnt_ff + 1'b1;
							if (&samp_cnt_ff)
								state_ff <= ST_STORE;
							else
								state_ff <= ST_START;
						end
					end
				end
				ST_STORE: begin
					conv_start_ff <= 1'b0;
					if (avg_vld) begin
						state_ff <= ST_START;
						if (chan_ff == `CHAN_REMOTE_TWO)
							chan_ff <= `CHAN_LOCAL;
						else
							chan_ff <= chan_ff + 2'h1;
					end
				end
				default: begin
					state_ff <= ST_START;
					conv_start_ff <= 1'b0;
				end
			endcase
		end
	end

	// Integer byte and fraction bits are written in the same edge.
	always @(posedge mclk) begin
		if (sys_rst) begin
			live_loc_ff <= `RESULT_RESET;
			live_r1_ff <= `RESULT_RESET;
			live_r2_ff <= `RESULT_RESET;
			live_loc_frac_ff <= `FRACTION_RESET;
			live_r1_frac_ff <= `FRACTION_RESET;
			live_r2_frac_ff <= `FRACTION_RESET;
		end else if (state_ff[2] && avg_vld) begin
			case (chan_ff)
				`CHAN_REMOTE_ONE: begin
					live_r1_ff <= code[9:2];
					live_r1_frac_ff <= code[1:0];
				end
				`CHAN_REMOTE_TWO: begin
					live_r2_ff <= code[9:2];
					live_r2_frac_ff <= code[1:0];
				end
				default: begin
					live_loc_ff <= code[9:2];
					live_loc_frac_ff <= code[1:0];
				end
			endcase
		end
	end

	// Register reads that set the freeze and that count toward releasing it.
	assign rd_frac = reg_rd & (reg_addr == `ADDR_TEMPERATURE_FRACTION_BITS);
	assign rd_hit = {reg_rd & (reg_addr == `ADDR_REMOTE_TWO_VALUE),
		reg_rd & (reg_addr == `ADDR_LOCAL_TEMPERATURE_VALUE),
		reg_rd & (reg_addr == `ADDR_REMOTE_ONE_VALUE)};
	assign nxt_seen = seen_ff | rd_hit;

	// A fraction read freezes; the last value read releases it.
	// A new fraction read restarts the tally, so it wins over a release.
	always @(posedge mclk) begin
		if (sys_rst) begin
			freeze_ff <= 1'b0;
			seen_ff <= 3'h0;
		end else if (rd_frac) begin
			freeze_ff <= 1'b1;
			seen_ff <= 3'h0;
		end else if (freeze_ff) begin
			if (&nxt_seen) begin
				freeze_ff <= 1'b0;
				seen_ff <= 3'h0;
			end else begin
				seen_ff <= nxt_seen;
			end
		end
	end

	// Visible copies follow the live results only while unfrozen.
	always @(posedge mclk) begin
		if (sys_rst) begin
			vis_loc_ff <= `RESULT_RESET;
			vis_r1_ff <= `RESULT_RESET;
			vis_r2_ff <= `RESULT_RESET;
			vis_frac_ff <= 8'h00;
		end else if (!freeze_ff && !rd_frac) begin
			vis_loc_ff <= live_loc_ff;
			vis_r1_ff <= live_r1_ff;
			vis_r2_ff <= live_r2_ff;
			vis_frac_ff <= {live_r2_frac_ff, live_loc_frac_ff,
				live_r1_frac_ff, 2'h0};
		end
	end

	// Offset and range configuration writes.
	always @(posedge mclk) begin
		if (sys_rst) begin
			off_r1_ff <= `OFFSET_RESET;
			off_loc_ff <= `OFFSET_RESET;
			off_r2_ff <= `OFFSET_RESET;
			range_cfg_ff <= `RANGE_CONFIG_RESET;
		end else if (reg_wr) begin
			case (reg_addr)
				`ADDR_REMOTE_ONE_OFFSET: off_r1_ff <= reg_wdata;
				`ADDR_LOCAL_OFFSET: off_loc_ff <= reg_wdata;
				`ADDR_REMOTE_TWO_OFFSET: off_r2_ff <= reg_wdata;
				`ADDR_RANGE_CONFIG: range_cfg_ff <= reg_wdata[1:0];
				default: range_cfg_ff <= range_cfg_ff;
			endcase
		end
	end

	// Read data stand in the cycle after the strobe; unmapped reads zero.
	always @(posedge mclk) begin
		if (sys_rst) begin
			reg_rdata_ff <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				`ADDR_REMOTE_ONE_VALUE: reg_rdata_ff <= vis_r1_ff;
				`ADDR_LOCAL_TEMPERATURE_VALUE: reg_rdata_ff <= vis_loc_ff;
				`ADDR_REMOTE_TWO_VALUE: reg_rdata_ff <= vis_r2_ff;
				`ADDR_TEMPERATURE_FRACTION_BITS: reg_rdata_ff <= vis_frac_ff;
				`ADDR_REMOTE_ONE_OFFSET: reg_rdata_ff <= off_r1_ff;
				`ADDR_LOCAL_OFFSET: reg_rdata_ff <= off_loc_ff;
				`ADDR_REMOTE_TWO_OFFSET: reg_rdata_ff <= off_r2_ff;
				`ADDR_RANGE_CONFIG: reg_rdata_ff <= {6'h00, range_cfg_ff};
				default: reg_rdata_ff <= 8'h00;
			endcase
		end else begin
			reg_rdata_ff <= 8'h00;
		end
	end

endmodule // temp_result_formatter

// File: fmt_checker_properties.sv
// Purpose: Port checker of the result formatter.
// Assumes: One clock, synchronous reset.
// Notes: Helper registers track the conversion run.
`timescale 1ns/10ps
module fmt_checker #(
	parameter CONV_WIDTH = 12
) (
	// Clock and reset.
	input wire mclk,
	input wire sys_rst,
	// Register port.
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_rdata_ff,
	// Front end.
	input wire conv_start_ff,
	input wire [1:0] chan_sel_ff,
	input wire [1:0] cur_mult_ff,
	input wire conv_done,
	input wire signed [CONV_WIDTH-1:0] conv_data
);
	reg [1:0] last_chan_ff;
	reg [1:0] last_mult_ff;
	reg [5:0] run_ff;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);
	// Counts requests of one channel, so a short run is caught.
	always @(posedge mclk) begin
		if (sys_rst) begin
			last_chan_ff <= 2'h0;
			last_mult_ff <= 2'h0;
			run_ff <= 6'h00;
		end else if (conv_start_ff) begin
			last_chan_ff <= chan_sel_ff;
			last_mult_ff <= cur_mult_ff;
			run_ff <= (chan_sel_ff == last_chan_ff) ? run_ff + 6'h01 : 6'h01;
		end
	end
	a_rdata_idle: assert property (!reg_rd |=> reg_rdata_ff == 8'h00)
		else $error("read data not zero");
	a_start_pulse: assert property (conv_start_ff |=> !conv_start_ff)
		else $error("start longer than one cycle");
	a_local_base: assert property (conv_start_ff && chan_sel_ff == 2'h0
		|-> cur_mult_ff == 2'h0) else $error("local current wrong");
	a_remote_mult: assert property (conv_start_ff && chan_sel_ff != 2'h0
		|-> cur_mult_ff != 2'h0) else $error("remote current wrong");
	a_mult_order: assert property (conv_start_ff && cur_mult_ff == 2'h2
		|-> last_mult_ff == 2'h1 && last_chan_ff == chan_sel_ff)
		else $error("second multiple out of order");
	a_sel_hold: assert property (!conv_start_ff |-> $stable(chan_sel_ff)
		&& $stable(cur_mult_ff)) else $error("select moved");
	a_run_length: assert property (conv_start_ff
		&& chan_sel_ff != last_chan_ff
		|-> run_ff == (last_chan_ff == 2'h0 ? 6'h10 : 6'h20))
		else $error("wrong sample count");
	a_chan_order: assert property (conv_start_ff
		&& chan_sel_ff != last_chan_ff
		|-> chan_sel_ff == (last_chan_ff == 2'h2 ? 2'h0 : last_chan_ff + 2'h1))
		else $error("channel order wrong");
	a_done_restart: assert property (conv_done |-> ##[1:8] conv_start_ff)
		else $error("no restart after done");
	c_remote_two: cover property (conv_start_ff && chan_sel_ff == 2'h2);
	c_freeze: cover property (reg_rd && reg_addr == 8'h77);
	c_offset: cover property (reg_wr && reg_addr == 8'h71);
endmodule // fmt_checker
bind temp_result_formatter fmt_checker #(.CONV_WIDTH(CONV_WIDTH)) fmt_checker_i (
	.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata_ff(reg_rdata_ff), .conv_start_ff(conv_start_ff),
	.chan_sel_ff(chan_sel_ff), .cur_mult_ff(cur_mult_ff),
	.conv_done(conv_done), .conv_data(conv_data));

// File: fe_model.sv
// Purpose: Behavioural analog front end.
// Assumes: One answer per request, LAT cycles later.
// Notes: Remote readings straddle the value by one quarter, and whole
//   samples swing by half a degree so only a true average recovers it.
`timescale 1ns/10ps
module fe_model #(
	parameter LAT = 3
) (
	// Clock and reset.
	input wire mclk,
	input wire sys_rst,
	// Requests.
	input wire conv_start_ff,
	input wire [1:0] chan_sel_ff,
	input wire [1:0] cur_mult_ff,
	// Temperatures in quarter degrees.
	input wire signed [11:0] t_loc,
	input wire signed [11:0] t_r1,
	input wire signed [11:0] t_r2,
	// Answer.
	output reg conv_done,
	output reg signed [11:0] conv_data
);
	integer cnt;
	reg dith;
	wire signed [11:0] val;
	wire signed [11:0] step;
	wire signed [11:0] dev;
	// Temperature of the sensor that is selected.
	assign val = (chan_sel_ff == 2'h1) ? t_r1 :
		(chan_sel_ff == 2'h2) ? t_r2 : t_loc;
	// First multiple reads low, second high; their mean is val.
	assign step = {{11{cur_mult_ff[0]}}, |cur_mult_ff};
	// Alternate samples sit above and below, so a block that kept a
	// single sample instead of averaging an even run would read off.
	assign dev = dith ? 12'h002 : 12'hffe;
	// Data toggles outside the done cycle so stale use shows up.
	always @(posedge mclk) begin
		if (sys_rst) begin
			cnt <= 0;
			dith <= 1'b0;
			conv_done <= 1'b0;
			conv_data <= 12'h000;
		end else if (cnt == 1 && !conv_start_ff) begin
			cnt <= 0;
			conv_done <= 1'b1;
			conv_data <= val + step + dev;
			// A sample ends with a local reading or the second multiple.
			if (cur_mult_ff != 2'h1)
				dith <= ~dith;
		end else begin
			conv_done <= 1'b0;
			conv_data <= ~conv_data;
			if (conv_start_ff)
				cnt <= LAT;
			else if (cnt > 0)
				cnt <= cnt - 1;
		end
	end
endmodule // fe_model

// File: temp_result_formatter_test.sv
// Purpose: Self-checking bench of the result formatter.
// Assumes: Front end answers three cycles after a request.
// Notes: Scenarios from t_ext to t_offset wait whole rounds before reading results.
`timescale 1ns/10ps
module temp_result_formatter_test;
	reg mclk = 1'b0;
	reg sys_rst = 1'b1;
	reg [7:0] reg_addr = 8'h00;
	reg [7:0] reg_wdata = 8'h00;
	reg reg_wr = 1'b0;
	reg reg_rd = 1'b0;
	reg signed [11:0] t_loc = 12'h000;
	reg signed [11:0] t_r1 = 12'h000;
	reg signed [11:0] t_r2 = 12'h000;
	wire [7:0] reg_rdata_ff;
	wire conv_start_ff;
	wire [1:0] chan_sel_ff;
	wire [1:0] cur_mult_ff;
	wire conv_done;
	wire signed [11:0] conv_data;
	integer failures = 0;
	integer num_checks = 0;
	// Clock of 100 MHz.
	always #5 mclk = ~mclk;
	temp_result_formatter temp_result_formatter_i (.mclk(mclk),
		.sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
		.conv_start_ff(conv_start_ff), .chan_sel_ff(chan_sel_ff),
		.cur_mult_ff(cur_mult_ff), .conv_done(conv_done),
		.conv_data(conv_data));
	fe_model fe_model_i (.mclk(mclk), .sys_rst(sys_rst),
		.conv_start_ff(conv_start_ff), .chan_sel_ff(chan_sel_ff),
		.cur_mult_ff(cur_mult_ff), .t_loc(t_loc), .t_r1(t_r1), .t_r2(t_r2),
		.conv_done(conv_done), .conv_data(conv_data));
	task wrap_up;
		begin
			$display("checks %0d failures %0d", num_checks, failures);
			if (failures == 0 && num_checks > 0)
				$display("ALL TESTS PASSED");
			else
				$display("TESTS FAILED");
			$finish;
		end
	endtask
	task wr(input [7:0] a, input [7:0] d);
		begin
			@(posedge mclk);
			reg_addr <= a;
			reg_wdata <= d;
			reg_wr <= 1'b1;
			@(posedge mclk);
			reg_wr <= 1'b0;
		end
	endtask
	// Read data is looked at in the one cycle where it stands.
	task rd(input [7:0] a, input [7:0] exp);
		begin
			@(posedge mclk);
			reg_addr <= a;
			reg_rd <= 1'b1;
			@(posedge mclk);
			reg_rd <= 1'b0;
			#1;
			num_checks = num_checks + 1;
			if (reg_rdata_ff !== exp) begin
				failures = failures + 1;
				$display("CHECK FAILED reg %h exp %h seen %h", a, exp, reg_rdata_ff);
			end
		end
	endtask
	// A round ends when the channel comes back to local.
	task wait_round;
		begin
			while (chan_sel_ff !== 2'h2) @(posedge mclk);
			while (chan_sel_ff !== 2'h0) @(posedge mclk);
			repeat (8) @(posedge mclk);
		end
	endtask
	// The second round is the first one made wholly of new values.
	task setv(input [7:0] cfg, input [11:0] l, input [11:0] a, input [11:0] b);
		begin
			wr(8'h7c, cfg);
			t_loc <= l;
			t_r1 <= a;
			t_r2 <= b;
			wait_round;
			wait_round;
		end
	endtask
	task rd4(input [7:0] f, input [7:0] v1, input [7:0] vl, input [7:0] v2);
		begin
			rd(8'h77, f);
			rd(8'h25, v1);
			rd(8'h26, vl);
			rd(8'h27, v2);
		end
	endtask
	task t_reset;
		begin
			rd4(8'h00, 8'h00, 8'h00, 8'h00);
			rd(8'h71, 8'h00);
			rd(8'h7c, 8'h00);
			wr(8'h26, 8'h55);
			rd(8'h26, 8'h00);
			rd(8'h30, 8'h00);
		end
	endtask
	task t_ext;
		begin
			setv(8'h00, 12'h066, 12'hf00, 12'h2fc);
			rd4(8'h20, 8'h00, 8'h59, 8'hff);
		end
	endtask
	task t_twos;
		begin
			setv(8'h03, 12'he00, 12'h1fc, 12'h029);
			rd4(8'h40, 8'h7f, 8'h80, 8'h0a);
		end
	endtask
	task t_clamp;
		begin
			setv(8'h02, 12'he00, 12'h258, 12'h000);
			rd4(8'h0c, 8'h7f, 8'hc0, 8'h00);
		end
	endtask
	task t_offset;
		begin
			wr(8'h71, 8'hfe);
			wr(8'h70, 8'h05);
			wr(8'h72, 8'h80);
			rd(8'h71, 8'hfe);
			rd(8'h72, 8'h80);
			setv(8'h00, 12'h066, 12'h000, 12'h000);
			rd4(8'h28, 8'h42, 8'h58, 8'h00);
		end
	endtask
	task t_freeze;
		begin
			rd(8'h77, 8'h28);
			t_loc <= 12'h0ca;
			wait_round;
			wait_round;
			rd(8'h26, 8'h58);
			rd(8'h25, 8'h42);
			rd(8'h27, 8'h00);
			repeat (4) @(posedge mclk);
			rd(8'h26, 8'h71);
		end
	endtask
	initial begin
		repeat (10) @(posedge mclk);
		sys_rst <= 1'b0;
		t_reset;
		t_ext;
		t_twos;
		t_clamp;
		t_offset;
		t_freeze;
		wrap_up;
	end
	// Cuts a hang short well beyond the expected run time.
	initial begin
		#300000;
		failures = failures + 1;
		wrap_up;
	end
endmodule // temp_result_formatter_test
